/* File: rtl/sfe_flash.sv */
`timescale 1ns/1ps
`include "sfe_map.svh"

// Notes on behaviour
// - Opcode D8h plus three address bytes erases one 64K-byte sector.
// - Sector erase decodes address bits 18..16; bits 23..19 ignored.
// - Erase leaves every affected bit at one.
// - Erase starts at chip select rise, ends once both timer and array walk finish, busy shows it.
// - Single-byte opcode C7h erases the whole array.
// - Page program writes 1 to 256 bytes inside one page, bits 18..8.
// - Program is opcode 02h, three address bytes; bits 18..0 used.
// - Program data captured each rising clock until chip select rises.
// - Beyond 256 data bytes only the latest 256 are programmed.
// - Programming starts only if chip select rises on a byte boundary.
// - Identification read refused while an internal write runs.
// - After 9Fh, maker then part code repeat while clocks continue.
// - ABh: 16 dummy bits, address byte; bit0 clear gives maker first.
// - ABh with address bit0 set gives part code first, then alternates.
// - ID output starts at last falling edge of final command byte (first for 9Fh, fourth for ABh); ends on CS.
// - Pause entered on hold fall with clock low, left on hold rise.
// - While paused output floats, serial input and clock ignored.
// - Write commands ignored unless chip select rises on a byte end.
// - Status write ignored when two or more bytes overlong.
// - Erase, program, status write need the write latch set first.
// - Busy reads one while an internal write runs, zero after.
// - Whole-array erase only when the protect level is zero.
// - Write latch clears itself when erase, program or status write ends.
module sfe_flash #(
  // Arbitrary identification values
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter logic [7:0] PART_CODE = 8'ha5,
  parameter int unsigned PU_READ_CYC =
    `SFE_T_PU_READ_US * `SFE_CLK_MHZ,
  parameter int unsigned PU_WRITE_CYC =
    `SFE_T_PU_WRITE_MS * 1000 * `SFE_CLK_MHZ,
  parameter int unsigned SECT_ERASE_CYC =
    `SFE_T_SECT_ERASE_MS * 1000 * `SFE_CLK_MHZ,
  parameter int unsigned CHIP_ERASE_CYC =
    `SFE_T_CHIP_ERASE_MS * 1000 * `SFE_CLK_MHZ,
  parameter int unsigned PAGE_PROG_CYC =
    `SFE_T_PAGE_PROG_US * `SFE_CLK_MHZ,
  parameter int unsigned STAT_WRITE_CYC =
    `SFE_T_STAT_WRITE_MS * 1000 * `SFE_CLK_MHZ
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Serial link
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  input wire logic hold_b,
  output logic so,
  output logic so_oe,
  // Status
  output logic busy,
  output logic write_latch,
  // Array inspection
  input wire logic [18:0] peek_addr,
  output logic [7:0] peek_data
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_protected(input logic [18:0] a,
                                        input logic [2:0] lvl);
    logic p;
    p = 1'b0;
    case (lvl)
      3'h0: p = 1'b0;
      3'h1: p = (a[18:16] == 3'h7);
      3'h2: p = (a[18:17] == 2'h3);
      3'h3: p = a[18];
      default: p = 1'b1;
    endcase
    return p;
  endfunction : is_protected

  function automatic logic [25:0] cycles(input int unsigned n);
    return 26'(n - 1);
  endfunction : cycles

  // ----------------------------------------------------------------
  // Link domain, rising serial clock
  // ----------------------------------------------------------------
  sfe_pkg::sfe_link_t lk;
  sfe_pkg::sfe_link_t next_lk;
  sfe_pkg::sfe_link_t snap;
  sfe_pkg::sfe_lsync_t ls;
  sfe_pkg::sfe_out_t ot;
  sfe_pkg::sfe_out_t next_ot;
  sfe_pkg::sfe_core_t q;
  sfe_pkg::sfe_core_t next_q;
  logic [7:0] pbuf [0:255];
  logic [7:0] mem [0:`SFE_ARRAY_WORDS-1];
  logic [7:0] in_byte;
  logic pbuf_we;
  logic mem_we;
  logic [18:0] mem_wa;
  logic [7:0] mem_wd;

  assign in_byte = {lk.shreg, si};

  always_comb begin
    next_lk = lk;
    pbuf_we = 1'b0;
    if (hold_b) begin
      next_lk.bitc = lk.bitc + 3'h1;
      next_lk.shreg = in_byte[6:0];
      if (lk.bitc == 3'h7) begin
        if (lk.nbytes != `SFE_LEN_SAT) begin
          next_lk.nbytes = lk.nbytes + 3'h1;
        end
        if (lk.nbytes == 3'h0) begin
          next_lk.opcode = in_byte;
          next_lk.id_refused = ls.blk_s;
        end else if (lk.nbytes <= `SFE_LAST_ADDR_BYTE) begin
          next_lk.addr = {lk.addr[15:0], in_byte};
          if (lk.nbytes == `SFE_LAST_ADDR_BYTE) begin
            next_lk.col = in_byte;
          end
        end else if (lk.opcode == `SFE_OP_PAGE_PROG) begin
          // Column wraps in the page so the newest 256 bytes survive
          pbuf_we = 1'b1;
          next_lk.valid[lk.col] = 1'b1;
          next_lk.col = lk.col + 8'h01;
        end
      end
    end
  end

  // Frame state clears while chip select is high
  always_ff @(posedge sck or posedge cs_b) begin
    if (cs_b) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: frame snapshot and page buffer
  // ----------------------------------------------------------------
  // Survives chip select rise; the core reads it after the frame
  always_ff @(posedge sck) begin
    snap <= next_lk;
  end

  always_ff @(posedge sck) begin
    if (pbuf_we) begin
      pbuf[lk.col] <= in_byte;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: refusal level crossing
  // ----------------------------------------------------------------
  // Refusal level from the core; settles well inside the opcode byte
  always_ff @(posedge sck or posedge cs_b) begin
    if (cs_b) begin
      ls <= '1;
    end else begin
      ls.blk_m <= q.id_block;
      ls.blk_s <= ls.blk_m;
    end
  end

  // ----------------------------------------------------------------
  // Link domain, falling serial clock: identification output
  // ----------------------------------------------------------------
  logic id_live;
  logic sel_now;
  logic [7:0] code;

  always_comb begin
    next_ot = ot;
    id_live = ~lk.id_refused && (lk.bitc == 3'h0) &&
              (((lk.opcode == `SFE_OP_ID_LONG) &&
                (lk.nbytes >= `SFE_LEN_OPCODE)) ||
               ((lk.opcode == `SFE_OP_ID_SHORT) &&
                (lk.nbytes >= `SFE_LEN_ADDR_CMD)));
    sel_now = ot.run ? ~ot.sel :
              ((lk.opcode == `SFE_OP_ID_SHORT) & lk.addr[0]);
    code = sel_now ? PART_CODE : MAKER_CODE;
    if (hold_b) begin
      if (id_live) begin
        next_ot.so = code[7];
        next_ot.oreg = code[6:0];
        next_ot.sel = sel_now;
        next_ot.run = 1'b1;
      end else if (ot.run) begin
        next_ot.so = ot.oreg[6];
        next_ot.oreg = {ot.oreg[5:0], 1'b0};
      end
    end
  end

  always_ff @(negedge sck or posedge cs_b) begin
    if (cs_b) begin
      ot <= '0;
    end else begin
      ot <= next_ot;
    end
  end

  assign so = ot.so;

  // ----------------------------------------------------------------
  // Core domain: frame decode, timer and array walk
  // ----------------------------------------------------------------
  logic frame_end;
  logic whole;

  always_comb begin
    next_q = q;
    mem_we = 1'b0;
    mem_wa = q.ptr;
    mem_wd = `SFE_ERASED_BYTE;
    frame_end = q.cs_s & ~q.cs_d;
    whole = (snap.bitc == 3'h0);

    next_q.cs_m = cs_b;
    next_q.cs_s = q.cs_m;
    next_q.cs_d = q.cs_s;
    next_q.drv_m = ot.run;
    next_q.drv_s = q.drv_m;
    next_q.hold_m = hold_b;
    next_q.hold_s = q.hold_m;
    // Output floats when paused or deselected
    next_q.so_oe = q.drv_s & q.hold_s & ~q.cs_s;
    next_q.peek = mem[peek_addr];

    // Internal power-on protection of the host wait times
    if (!q.pu_wr) begin
      next_q.pu_cnt = q.pu_cnt + 22'h00_0001;
    end
    if (32'(q.pu_cnt) >= PU_READ_CYC - 1) begin
      next_q.pu_rd = 1'b1;
    end
    if (32'(q.pu_cnt) >= PU_WRITE_CYC - 1) begin
      next_q.pu_wr = 1'b1;
    end
    if (q.timer != 26'h000_0000) begin
      next_q.timer = q.timer - 26'h000_0001;
    end

    case (q.op)
      sfe_pkg::SFE_IDLE: begin
        if (frame_end && whole && q.pu_wr) begin
          case (snap.opcode)
            `SFE_OP_WR_ENABLE: begin
              if (snap.nbytes == `SFE_LEN_OPCODE) begin
                next_q.wen = 1'b1;
              end
            end
            `SFE_OP_WR_DISABLE: begin
              if (snap.nbytes == `SFE_LEN_OPCODE) begin
                next_q.wen = 1'b0;
              end
            end
            `SFE_OP_SECT_ERASE: begin
              if (snap.nbytes == `SFE_LEN_ADDR_CMD && q.wen &&
                  !is_protected(snap.addr[18:0], q.bp)) begin
                next_q.op = sfe_pkg::SFE_ERASE;
                next_q.ptr = {snap.addr[18:16], `SFE_SECT_FIRST};
                next_q.last = {snap.addr[18:16], `SFE_SECT_LAST};
                next_q.timer = cycles(SECT_ERASE_CYC);
                next_q.busy = 1'b1;
              end
            end
            `SFE_OP_CHIP_ERASE: begin
              if (snap.nbytes == `SFE_LEN_OPCODE && q.wen &&
                  q.bp == 3'h0) begin
                next_q.op = sfe_pkg::SFE_ERASE;
                next_q.ptr = `SFE_CHIP_FIRST;
                next_q.last = `SFE_CHIP_LAST;
                next_q.timer = cycles(CHIP_ERASE_CYC);
                next_q.busy = 1'b1;
              end
            end
            `SFE_OP_PAGE_PROG: begin
              if (snap.nbytes >= `SFE_LEN_PROG_MIN && q.wen &&
                  !is_protected(snap.addr[18:0], q.bp)) begin
                next_q.op = sfe_pkg::SFE_PROG;
                next_q.ptr = {snap.addr[18:8], `SFE_PAGE_FIRST};
                next_q.last = {snap.addr[18:8], `SFE_PAGE_LAST};
                next_q.timer = cycles(PAGE_PROG_CYC);
                next_q.busy = 1'b1;
              end
            end
            `SFE_OP_STAT_WRITE: begin
              // Overlong by one byte is tolerated, by two refused
              if ((snap.nbytes == `SFE_LEN_STAT_MIN ||
                   snap.nbytes == `SFE_LEN_STAT_MAX) && q.wen) begin
                next_q.op = sfe_pkg::SFE_SRW;
                next_q.bp = (snap.nbytes == `SFE_LEN_STAT_MIN) ?
                            snap.addr[`SFE_BP_LSB +: 3] :
                            snap.addr[8 + `SFE_BP_LSB +: 3];
                next_q.timer = cycles(STAT_WRITE_CYC);
                next_q.busy = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      sfe_pkg::SFE_ERASE, sfe_pkg::SFE_PROG: begin
        // The walk parks on the last cell; rewriting it is harmless
        mem_we = (q.op == sfe_pkg::SFE_ERASE) | snap.valid[q.ptr[7:0]];
        mem_wd = (q.op == sfe_pkg::SFE_ERASE) ? `SFE_ERASED_BYTE :
                 (mem[q.ptr] & pbuf[q.ptr[7:0]]);
        if (q.ptr != q.last) begin
          next_q.ptr = q.ptr + 19'h0_0001;
        end else if (q.timer == 26'h000_0000) begin
          next_q.op = sfe_pkg::SFE_IDLE;
          next_q.busy = 1'b0;
          next_q.wen = 1'b0;
        end
      end
      sfe_pkg::SFE_SRW: begin
        if (q.timer == 26'h000_0000) begin
          next_q.op = sfe_pkg::SFE_IDLE;
          next_q.busy = 1'b0;
          next_q.wen = 1'b0;
        end
      end
      default: begin
        next_q.op = sfe_pkg::SFE_IDLE;
        next_q.busy = 1'b0;
      end
    endcase

    next_q.id_block = (next_q.op != sfe_pkg::SFE_IDLE) | ~q.pu_rd;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
      q.cs_m <= 1'b1;
      q.cs_s <= 1'b1;
      q.cs_d <= 1'b1;
      q.hold_m <= 1'b1;
      q.hold_s <= 1'b1;
      q.wen <= `SFE_RST_WEN;
      q.bp <= `SFE_RST_BP;
      q.id_block <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: array storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign so_oe = q.so_oe;
  assign busy = q.busy;
  assign write_latch = q.wen;
  assign peek_data = q.peek;

endmodule : sfe_flash

/* File: rtl/sfe_map.svh */
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define SFE_OP_SECT_ERASE 8'hd8
`define SFE_OP_CHIP_ERASE 8'hc7
`define SFE_OP_PAGE_PROG 8'h02
`define SFE_OP_ID_LONG 8'h9f
`define SFE_OP_ID_SHORT 8'hab
`define SFE_OP_WR_ENABLE 8'h06
`define SFE_OP_WR_DISABLE 8'h04
`define SFE_OP_STAT_WRITE 8'h01

// ----------------------------------------------------------------
// Command lengths in whole bytes, opcode included
// ----------------------------------------------------------------
`define SFE_LEN_OPCODE 3'h1
`define SFE_LEN_STAT_MIN 3'h2
`define SFE_LEN_STAT_MAX 3'h3
`define SFE_LEN_ADDR_CMD 3'h4
`define SFE_LEN_PROG_MIN 3'h5
`define SFE_LEN_SAT 3'h7
`define SFE_LAST_ADDR_BYTE 3'h3

// ----------------------------------------------------------------
// Array layout and values
// ----------------------------------------------------------------
`define SFE_ERASED_BYTE 8'hff
`define SFE_SECT_FIRST 16'h0000
`define SFE_SECT_LAST 16'hffff
`define SFE_PAGE_FIRST 8'h00
`define SFE_PAGE_LAST 8'hff
`define SFE_CHIP_FIRST 19'h0_0000
`define SFE_CHIP_LAST 19'h7_ffff
`define SFE_ARRAY_WORDS 524288
`define SFE_BP_LSB 2
`define SFE_RST_BP 3'h0
`define SFE_RST_WEN 1'h0

// ----------------------------------------------------------------
// Timing, clock in MHz and times as printed
// ----------------------------------------------------------------
`define SFE_CLK_MHZ 200
`define SFE_T_PU_READ_US 100
`define SFE_T_PU_WRITE_MS 10
`define SFE_T_SECT_ERASE_MS 80
`define SFE_T_CHIP_ERASE_MS 200
`define SFE_T_PAGE_PROG_US 2000
`define SFE_T_STAT_WRITE_MS 5

`endif

/* File: rtl/sfe_pkg.sv */
package sfe_pkg;

  typedef enum logic [1:0] {
    SFE_IDLE,
    SFE_ERASE,
    SFE_PROG,
    SFE_SRW
  } sfe_op_t;

  // Link side, rising serial clock
  typedef struct packed {
    logic [2:0] bitc;
    logic [2:0] nbytes;
    logic [6:0] shreg;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] col;
    logic [255:0] valid;
    logic id_refused;
  } sfe_link_t;

  // Link side, falling serial clock
  typedef struct packed {
    logic run;
    logic sel;
    logic [6:0] oreg;
    logic so;
  } sfe_out_t;

  // Link side synchroniser for the refusal level
  typedef struct packed {
    logic blk_m;
    logic blk_s;
  } sfe_lsync_t;

  // Core side, system clock
  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic drv_m;
    logic drv_s;
    logic hold_m;
    logic hold_s;
    sfe_op_t op;
    logic [18:0] ptr;
    logic [18:0] last;
    logic [25:0] timer;
    logic wen;
    logic [2:0] bp;
    logic [21:0] pu_cnt;
    logic pu_rd;
    logic pu_wr;
    logic id_block;
    logic busy;
    logic so_oe;
    logic [7:0] peek;
  } sfe_core_t;

endpackage : sfe_pkg

/* File: test/sfe_flash_monitor.sv */
`timescale 1ns/1ps
module sfe_flash_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link inputs
  input wire logic cs_b,
  input wire logic hold_b,
  // Outputs under watch
  input wire logic so_oe,
  input wire logic busy,
  input wire logic write_latch
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Write operations
  // ----------------------------------------------------------------
  a_latch_clear_done: assert property ($fell(busy) |-> !write_latch)
    else $error("write latch left set after busy fell");
  a_busy_needs_latch: assert property ($rose(busy) |-> write_latch)
    else $error("busy rose without the write latch");
  a_busy_after_cs: assert property (
    $rose(busy) |-> cs_b && $past(cs_b, 2))
    else $error("busy rose while chip select was low");
  a_busy_holds: assert property ($rose(busy) |=> busy [*8])
    else $error("busy dropped too early");

  // ----------------------------------------------------------------
  // Output enable
  // ----------------------------------------------------------------
  // Enable lags the link by a few clocks, hence the settle spans
  a_no_id_busy: assert property (busy && $past(busy, 4) |-> !so_oe)
    else $error("output driven during a write");
  a_oe_off_idle: assert property (cs_b [*6] |-> !so_oe)
    else $error("output driven with chip select high");
  a_oe_off_hold: assert property (!hold_b [*6] |-> !so_oe)
    else $error("output driven while paused");
  a_oe_in_frame: assert property ($rose(so_oe) |-> !cs_b && hold_b)
    else $error("output enabled outside a frame");
endmodule : sfe_flash_monitor

bind sfe_flash sfe_flash_monitor sfe_flash_monitor_i (
  .clk(clk),
  .rst_b(rst_b),
  .cs_b(cs_b),
  .hold_b(hold_b),
  .so_oe(so_oe),
  .busy(busy),
  .write_latch(write_latch)
);

/* File: test/sfe_flash_host.sv */
`timescale 1ns/1ps
module sfe_flash_host (
  // Link to the device
  output logic sck,
  output logic cs_b,
  output logic si,
  output logic hold_b,
  input wire logic so
);
  localparam realtime HALF = 7.5;

  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b1;
    hold_b = 1'b1;
  end

  // Odd offset keeps link edges off the system clock edges
  task automatic start();
    #1.1;
    cs_b = 1'b0;
    #HALF;
  endtask : start

  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      input int nb);
    int i;
    q = 8'h00;
    for (i = 0; i < nb; i++) begin
      si = d[7 - i];
      #HALF;
      sck = 1'b1;
      q = {q[6:0], so};
      #HALF;
      sck = 1'b0;
    end
  endtask : xfer

  // Released data line flips so a stale level is never trusted
  task automatic stop();
    #HALF;
    cs_b = 1'b1;
    si = ~si;
    #30;
  endtask : stop

  // Only called with the serial clock low
  task automatic hold_set(input logic lvl);
    #HALF;
    hold_b = lvl;
    #HALF;
  endtask : hold_set
endmodule : sfe_flash_host

/* File: test/sfe_flash_tb.sv */
`timescale 1ns/1ps
module sfe_flash_tb;
  // Arbitrary identification values, the design's untouched defaults
  localparam logic [7:0] MAKER = 8'h5a;
  localparam logic [7:0] PART = 8'ha5;
  typedef struct packed {
    logic [31:0] cmd;
    logic [2:0] nb;
    logic [7:0] first;
    logic [7:0] second;
  } sfe_row_t;
  localparam sfe_row_t ROWS [4] = '{
    '{32'h9f00_0000, 3'h1, MAKER, PART},
    '{32'hab00_0000, 3'h4, MAKER, PART},
    '{32'hab12_3401, 3'h4, PART, MAKER},
    '{32'habff_fffe, 3'h4, MAKER, PART}};

  logic clk;
  logic rst_b;
  logic sck;
  logic cs_b;
  logic si;
  logic hold_b;
  logic so;
  logic so_oe;
  logic busy;
  logic write_latch;
  logic [18:0] peek_addr;
  logic [7:0] peek_data;
  logic [7:0] q;
  int n_fail;
  int compares;
  int r;
  int k;

  sfe_flash #(
    .PU_READ_CYC(20),
    .PU_WRITE_CYC(40),
    .SECT_ERASE_CYC(100),
    .PAGE_PROG_CYC(300),
    .STAT_WRITE_CYC(50)
  ) sfe_flash_i (
    .clk(clk),
    .rst_b(rst_b),
    .sck(sck),
    .cs_b(cs_b),
    .si(si),
    .hold_b(hold_b),
    .so(so),
    .so_oe(so_oe),
    .busy(busy),
    .write_latch(write_latch),
    .peek_addr(peek_addr),
    .peek_data(peek_data)
  );

  sfe_flash_host sfe_flash_host_i (
    .sck(sck),
    .cs_b(cs_b),
    .si(si),
    .hold_b(hold_b),
    .so(so)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task automatic send(input logic [31:0] w, input int nb);
    logic [7:0] d;
    int i;
    for (i = 0; i < nb; i++) sfe_flash_host_i.xfer(w[31 - 8 * i -: 8], d, 8);
  endtask : send

  task automatic cmd(input logic [31:0] w, input int nb);
    sfe_flash_host_i.start();
    send(w, nb);
    sfe_flash_host_i.stop();
  endtask : cmd

  task automatic peek(input logic [18:0] a, input logic [7:0] exp);
    @(negedge clk);
    peek_addr = a;
    @(negedge clk);
    chk(peek_data, exp);
  endtask : peek

  task automatic wait_idle();
    int i;
    repeat (10) @(negedge clk);
    for (i = 0; i < 70000 && busy !== 1'b0; i++) @(negedge clk);
    chk({7'h00, busy}, 8'h00);
  endtask : wait_idle

  // Newer bytes carry the top bit so overwrites are visible
  function automatic logic [7:0] pat(input int n);
    return n[7:0] ^ ((n > 255) ? 8'h80 : 8'h00);
  endfunction : pat

  initial begin
    #450_000;
    n_fail++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    peek_addr = 19'h0_0000;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (50) @(negedge clk);
    for (r = 0; r < 4; r++) begin
      sfe_flash_host_i.start();
      send(ROWS[r].cmd, int'(ROWS[r].nb));
      for (k = 0; k < 3; k++) begin
        sfe_flash_host_i.xfer(8'hff, q, 8);
        chk(q, k[0] ? ROWS[r].second : ROWS[r].first);
      end
      chk({7'h00, so_oe}, 8'h01);
      sfe_flash_host_i.stop();
      chk({7'h00, so_oe}, 8'h00);
    end
    // Pause between the two code bytes, clocks ignored meanwhile
    sfe_flash_host_i.start();
    send(32'h9f00_0000, 1);
    sfe_flash_host_i.xfer(8'hff, q, 8);
    sfe_flash_host_i.hold_set(1'b0);
    sfe_flash_host_i.xfer(8'h00, q, 4);
    chk({7'h00, so_oe}, 8'h00);
    sfe_flash_host_i.hold_set(1'b1);
    sfe_flash_host_i.xfer(8'hff, q, 8);
    chk(q, PART);
    sfe_flash_host_i.stop();
    cmd(32'hd8f8_0000, 4);
    repeat (10) @(negedge clk);
    chk({7'h00, busy}, 8'h00);
    cmd(32'h0600_0000, 1);
    chk({7'h00, write_latch}, 8'h01);
    cmd(32'hd8f8_0000, 4);
    repeat (10) @(negedge clk);
    chk({7'h00, busy}, 8'h01);
    sfe_flash_host_i.start();
    send(32'h9f00_0000, 1);
    sfe_flash_host_i.xfer(8'hff, q, 8);
    chk({7'h00, so_oe}, 8'h00);
    sfe_flash_host_i.stop();
    wait_idle();
    chk({7'h00, write_latch}, 8'h00);
    peek(19'h0_0000, 8'hff);
    peek(19'h0_ffff, 8'hff);
    // Page 1 lies in the sector just erased
    cmd(32'h0600_0000, 1);
    sfe_flash_host_i.start();
    send(32'h0200_0100, 4);
    for (k = 0; k < 258; k++) sfe_flash_host_i.xfer(pat(k), q, 8);
    sfe_flash_host_i.stop();
    wait_idle();
    for (k = 0; k < 256; k++) begin
      peek({11'h001, k[7:0]}, pat(k < 2 ? k + 256 : k));
    end
    peek(19'h0_0200, 8'hff);
    cmd(32'h0600_0000, 1);
    sfe_flash_host_i.start();
    send(32'h0200_0300, 4);
    sfe_flash_host_i.xfer(8'h00, q, 8);
    sfe_flash_host_i.xfer(8'h00, q, 3);
    sfe_flash_host_i.stop();
    repeat (10) @(negedge clk);
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, write_latch}, 8'h01);
    peek(19'h0_0300, 8'hff);
    // Status write two bytes too long, then of proper length
    cmd(32'h0104_0000, 4);
    repeat (10) @(negedge clk);
    chk({7'h00, busy}, 8'h00);
    cmd(32'h0104_0000, 2);
    repeat (10) @(negedge clk);
    chk({7'h00, busy}, 8'h01);
    wait_idle();
    chk({7'h00, write_latch}, 8'h00);
    // Protect level one now blocks the whole-array erase
    cmd(32'h0600_0000, 1);
    cmd(32'hc700_0000, 1);
    repeat (10) @(negedge clk);
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, write_latch}, 8'h01);
    // One byte overlong is still taken; level back to zero
    cmd(32'h0100_0000, 3);
    repeat (10) @(negedge clk);
    chk({7'h00, busy}, 8'h01);
    wait_idle();
    cmd(32'h0600_0000, 1);
    cmd(32'h0400_0000, 1);
    chk({7'h00, write_latch}, 8'h00);
    cmd(32'h0600_0000, 1);
    cmd(32'hc700_0000, 1);
    repeat (10) @(negedge clk);
    chk({7'h00, busy}, 8'h01);
    // Second reset in the middle of the erase walk
    rst_b = 1'b0;
    repeat (20) @(negedge clk);
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, write_latch}, 8'h00);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, write_latch}, 8'h00);
    results();
  end
endmodule : sfe_flash_tb
